// File: design/ctt_regs.vh
// Register offsets, field positions and reset values of the core tick timer.
// Included by the timer design files; holds definitions only.
`ifndef CTT_REGS_VH
`define CTT_REGS_VH

// ==========================================================================
// Register byte offsets
`define CTT_OFS_CTRL 8'h00
`define CTT_OFS_RELOAD 8'h04
`define CTT_OFS_CURRENT 8'h08
`define CTT_OFS_IRQ_STAT 8'h0C
`define CTT_OFS_IRQ_MASK 8'h10

// ==========================================================================
// Control and status field positions
`define CTT_CTRL_ENABLE 0
`define CTT_CTRL_TICKINT 1
`define CTT_CTRL_CLKSRC 2
`define CTT_CTRL_ZFLAG 16

// ==========================================================================
// Interrupt status field positions
`define CTT_IRQ_ZERO 0

// ==========================================================================
// Widths and reset values
`define CTT_CNT_W 24
`define CTT_CNT_RST 24'h000000
`define CTT_RELOAD_RST 24'h000000
`define CTT_CNT_ONE 24'h000001
`define CTT_CNT_ZERO 24'h000000
`define CTT_SYNC_RST 1'b0

`endif

// File: design/ctt_sync.v
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes the input may change at any time relative to clk_sys_i.
`timescale 1ns/1ns
`include "ctt_regs.vh"

module ctt_sync (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire async_i,
    output reg sync_o
);

    reg stage1;
    reg stage2;
    reg stage3;

    // ======================================================================
    // Synchroniser chain
    // The first stage feeds only the second, so a metastable value is never seen by logic.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1 <= `CTT_SYNC_RST;
            stage2 <= `CTT_SYNC_RST;
            stage3 <= `CTT_SYNC_RST;
            sync_o <= `CTT_SYNC_RST;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_o <= stage3;
            end
        end
    end

endmodule // ctt_sync

// File: design/ctt_timer.v
// Core tick timer: 24-bit down counter with control, reload and current value
// registers, and an interrupt status and mask pair, reached over APB.
// Assumes an APB master on clk_sys_i and an asynchronous debug-halt level.
`timescale 1ns/1ns
`include "ctt_regs.vh"

module ctt_timer (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire debug_halt_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg irq_o,
    output reg tick_pend_o
);

    reg [`CTT_CNT_W-1:0] count;
    reg [`CTT_CNT_W-1:0] reload;
    reg enable;
    reg tickint;
    reg clksrc;
    reg zero_reached_flag;
    reg irq_stat;
    reg irq_mask;
    reg [31:0] next_rdata;
    reg next_err;
    reg next_irq_stat;
    wire halted;
    wire access;
    wire wr_done;
    wire rd_done;
    wire hit_ctrl;
    wire hit_reload;
    wire hit_current;
    wire hit_stat;
    wire hit_mask;
    wire wr_current;
    wire step;
    wire hit_zero;

    // ======================================================================
    // Debug halt synchroniser
    ctt_sync u_halt_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i(debug_halt_i),
        .sync_o(halted)
    );

    // ======================================================================
    // APB decode
    // One wait state: pready rises in the second access cycle, which lets read
    // data be registered without a combinational path to the bus.
    assign access = psel_i & penable_i;
    assign wr_done = access & pready_o & pwrite_i & ~pslverr_o;
    assign rd_done = access & pready_o & ~pwrite_i & ~pslverr_o;
    assign hit_ctrl = (paddr_i == `CTT_OFS_CTRL);
    assign hit_reload = (paddr_i == `CTT_OFS_RELOAD);
    assign hit_current = (paddr_i == `CTT_OFS_CURRENT);
    assign hit_stat = (paddr_i == `CTT_OFS_IRQ_STAT);
    assign hit_mask = (paddr_i == `CTT_OFS_IRQ_MASK);
    assign wr_current = wr_done & hit_current;

    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (1'b1)
            hit_ctrl: begin
                next_rdata[`CTT_CTRL_ENABLE] = enable;
                next_rdata[`CTT_CTRL_TICKINT] = tickint;
                next_rdata[`CTT_CTRL_CLKSRC] = clksrc;
                next_rdata[`CTT_CTRL_ZFLAG] = zero_reached_flag;
            end
            hit_reload: next_rdata[`CTT_CNT_W-1:0] = reload;
            hit_current: next_rdata[`CTT_CNT_W-1:0] = count;
            hit_stat: next_rdata[`CTT_IRQ_ZERO] = irq_stat;
            hit_mask: next_rdata[`CTT_IRQ_ZERO] = irq_mask;
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= access & ~pready_o;
            if (access & ~pready_o) begin
                pslverr_o <= next_err;
                prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
            end else begin
                pslverr_o <= 1'b0;
                prdata_o <= 32'h00000000;
            end
        end
    end

    // ======================================================================
    // Control registers
    // The clock source bit is stored only; the core clock always drives the count.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable <= 1'b0;
            tickint <= 1'b0;
            clksrc <= 1'b0;
            reload <= `CTT_RELOAD_RST;
            irq_mask <= 1'b0;
        end else if (wr_done) begin
            if (hit_ctrl) begin
                enable <= pwdata_i[`CTT_CTRL_ENABLE];
                tickint <= pwdata_i[`CTT_CTRL_TICKINT];
                clksrc <= pwdata_i[`CTT_CTRL_CLKSRC];
            end
            if (hit_reload) begin
                reload <= pwdata_i[`CTT_CNT_W-1:0];
            end
            if (hit_mask) begin
                irq_mask <= pwdata_i[`CTT_IRQ_ZERO];
            end
        end
    end

    // ======================================================================
    // Counter
    assign step = enable & ~halted & ~wr_current;
    assign hit_zero = step & (count == `CTT_CNT_ONE);

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= `CTT_CNT_RST;
        end else if (wr_current) begin
            count <= `CTT_CNT_ZERO;
        end else if (step) begin
            if (count == `CTT_CNT_ZERO) begin
                count <= reload;
            end else begin
                count <= count - `CTT_CNT_ONE;
            end
        end
    end

    // ======================================================================
    // Flag, events and interrupt
    // A zero crossing in the cycle of a clearing read still sets the flag.
    always @* begin
        next_irq_stat = irq_stat;
        if (rd_done & hit_stat) begin
            next_irq_stat = 1'b0;
        end
        if (hit_zero) begin
            next_irq_stat = 1'b1;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            zero_reached_flag <= 1'b0;
            irq_stat <= 1'b0;
            irq_o <= 1'b0;
            tick_pend_o <= 1'b0;
        end else begin
            if (hit_zero) begin
                zero_reached_flag <= 1'b1;
            end else if (wr_current) begin
                zero_reached_flag <= 1'b0;
            end else if (rd_done & hit_ctrl) begin
                zero_reached_flag <= 1'b0;
            end
            irq_stat <= next_irq_stat;
            irq_o <= next_irq_stat & irq_mask;
            tick_pend_o <= hit_zero & tickint;
        end
    end

endmodule // ctt_timer

// File: tb/ctt_timer_assertions.sv
// Checker for the tick timer APB slave.
// Sees only ctt_timer ports; the master holds its request until pready_o.
`timescale 1ns/1ns
module ctt_timer_chk (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire debug_halt_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire irq_o,
    input wire tick_pend_o
);
// ====
// Checks.
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!resetn_i);
wire acc = psel_i & penable_i;
wire cur = pready_o & (paddr_i == 8'h08);
wire okad = (paddr_i[7:2] <= 6'h04) & (paddr_i[1:0] == 2'h0);
chk_upper_zero: assert property (cur & !pwrite_i |-> prdata_o[31:24] == 8'h00)
    else $error("upper bits set");
chk_one_wait: assert property (acc & !pready_o |=> pready_o)
    else $error("no answer");
chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("long ready");
chk_ready_acc: assert property (pready_o |-> acc)
    else $error("stray ready");
chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("stray data");
chk_unmapped_err: assert property (pready_o |-> pslverr_o == !okad)
    else $error("wrong error");
chk_err_no_data: assert property (pslverr_o |-> prdata_o == 32'h0)
    else $error("error with data");
chk_clear_no_tick: assert property (cur & pwrite_i |=> !tick_pend_o)
    else $error("tick on clear");
chk_tick_spacing: assert property (tick_pend_o |=> !tick_pend_o)
    else $error("ticks too close");
cover property (cur & !pwrite_i);
cover property (cur & pwrite_i);
cover property ($rose(irq_o));
endmodule // ctt_timer_chk
bind ctt_timer ctt_timer_chk u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .debug_halt_i(debug_halt_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .tick_pend_o(tick_pend_o));

// File: tb/tb_ctt_timer.sv
// Self-checking bench for the tick timer over APB.
// Waits are bounded; reload 20 keeps tick periods short.
`timescale 1ns/1ns
module tb_ctt_timer;
// ====
// Bench.
logic clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
logic debug_halt_i = 0, pready_o, pslverr_o, irq_o, tick_pend_o, err;
logic [7:0] paddr_i = 8'h00;
logic [31:0] pwdata_i = 32'h0, prdata_o, rd, a;
int n_mismatch = 0, compares = 0, n;
always #25 clk_sys_i = ~clk_sys_i;
ctt_timer uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .debug_halt_i(debug_halt_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .tick_pend_o(tick_pend_o));
task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
        @(posedge clk_sys_i);
        k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // One idle edge keeps the next call from assigning psel again in this step.
    @(posedge clk_sys_i);
    if (k >= 20) begin
        n_mismatch++;
        wrap_up;
    end
endtask
// Sampling irq_o or tick_pend_o is exact: both come from registers.
task automatic wait_sig(input bit sel);
    n = 0;
    do begin
        @(posedge clk_sys_i);
        n++;
    end while ((sel ? irq_o : tick_pend_o) !== 1'b1 && n < 200);
    if (n >= 200) begin
        n_mismatch++;
        wrap_up;
    end
endtask
initial begin
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
        apb(1'b0, 8'(i * 4), 32'h0);
        chk(rd, 32'h0);
    end
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h04, 32'd20);
    apb(1'b1, 8'h00, 32'h3);
    wait_sig(1'b0);
    wait_sig(1'b0);
    chk(n, 21);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00010003);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000003);
    chk(irq_o, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd[31:1], irq_o}, 32'h0);
    debug_halt_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    apb(1'b0, 8'h08, 32'h0);
    a = rd;
    repeat (5) @(posedge clk_sys_i);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, a);
    debug_halt_i <= 1'b0;
    wait_sig(1'b1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    // A masked event is still recorded but must not raise the line.
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h00, 32'h1);
    repeat (12) @(posedge clk_sys_i);
    chk(irq_o, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[31:16], 16'h00FF);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    // Read-modify-write keeps the reserved byte; the count may move in between.
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h08, {8'h00, rd[23:0]});
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[31:24], 8'h00);
    wrap_up;
end
endmodule // tb_ctt_timer
